// >>> logic/swcan_pkg.sv
// Purpose: Shared constants and types for the single-wire CAN control logic
// Assumes: 250 MHz system clock
// Notes: Register offsets are byte addresses on the plain register port
`default_nettype none
package swcan_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TIMEOUT_US = 1000;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000 * 1000) / CLK_PERIOD_PS;
    localparam int RX_FILTER_NS = 40;
    localparam int RX_FILTER_CYCLES = (RX_FILTER_NS * 1000) / CLK_PERIOD_PS;
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATE = 4'h8;
    // Event bits, shared by status and mask
    localparam int EV_W = 4;
    localparam int EV_WAKE = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_GND_LOSS = 2;
    localparam int EV_MODE = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
    // State register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_DRIVE = 3;
    localparam int ST_WAKE_LVL = 4;
    localparam int ST_SLEW = 5;
    localparam int ST_LOAD_SW = 6;
    localparam int ST_RX_DOM = 7;
    // Operating modes, decoded from the two select inputs
    typedef enum logic [1:0] {
        mode_sleep,
        mode_high_speed,
        mode_wake_call,
        mode_normal
    } mode_type;
endpackage
`default_nettype wire

// >>> logic/cond_if.sv
// Purpose: Carries one raw pin level in and its conditioned level back
// Assumes: Single clock domain on the conditioned side
// Notes: Used between the controller top and its input conditioners
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
    logic raw;
    logic clean;
    modport src
    (
        output raw,
        input clean
    );
    modport flt
    (
        input raw,
        output clean
    );
endinterface
`default_nettype wire

// >>> logic/cond_filter.sv
// Purpose: Two-flop synchroniser followed by a stability filter
// Assumes: raw is asynchronous to clk
// Notes: clean changes only after the synced level held FILT_LEN cycles
`timescale 1ns/1ps
`default_nettype none
module cond_filter
#(
    parameter int FILT_LEN = 1,
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    cond_if.flt port // Raw level in, clean level out
);
    localparam int CW = (FILT_LEN < 2) ? 1 : $clog2(FILT_LEN);
    localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

    typedef struct packed {
        logic meta;
        logic sync;
        logic clean;
        logic [CW-1:0] cnt;
    } cond_state_type;

    cond_state_type st_ff;
    cond_state_type nxt_st;

    if (FILT_LEN < 1)
    begin : g_chk
        $error("cond_filter: FILT_LEN must be at least 1");
    end

    // ------------------------------------------------------------
    // Synchronise, then accept a new level once it stays put
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.meta = port.raw;
        nxt_st.sync = st_ff.meta; // First stage feeds only this flop
        if (st_ff.sync == st_ff.clean)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == LAST)
        begin
            nxt_st.clean = st_ff.sync;
            nxt_st.cnt = '0;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    // Reset level is the pad's idle level, so startup looks undriven
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_ff <= '{meta: RESET_VAL, sync: RESET_VAL, clean: RESET_VAL, cnt: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign port.clean = st_ff.clean;
endmodule
`default_nettype wire

// >>> logic/swcan_ctrl.sv
// Purpose: Control logic of a single-wire CAN transceiver
// Assumes: Pins and bus comparators are asynchronous; one 250 MHz clock
// Notes: Analog shaping, thresholds and supply lockout live outside
//
// Function
// - Selects 00 sleep, 10 high-speed, 01 wake-up call, 11 normal.
// - Undriven mode-select inputs read low through a pull-down.
// - Transmit input is active low; undriven means recessive.
// - Transmit low drives bus dominant high outside sleep; high releases it recessive.
// - Receive output pulled low while bus is dominant, released otherwise.
// - Driver switches off when transmit stays low past the timeout.
// - Transmit returning high clears the timeout at once.
// - In sleep only wake-level traffic reaches the receive output.
// - Sleep is left only by changing the mode-select inputs.
// - High-speed mode switches off slew-rate control.
// - Wake-up call mode sends every message at wake-up level.
// - Normal mode sends at normal level with wave shaping on.
// - Awake modes forward sensed bus data through a fixed filter.
// - Load switch to ground opens on loss of ground.
// - Loss-of-ground circuit stays active in sleep too.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module swcan_ctrl
    import swcan_pkg::*;
#(
    parameter int DOM_TIMEOUT_CYCLES = TIMEOUT_CYCLES,
    parameter int RX_FILT_CYCLES = RX_FILTER_CYCLES
)
(
    input wire logic clk, // 250 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic tx_data_n, // Transmit request, low = dominant
    input wire logic mode_select0, // Mode select bit 0
    input wire logic mode_select1, // Mode select bit 1
    input wire logic bus_sense_norm, // Bus above normal threshold
    input wire logic bus_sense_wake, // Bus above wake-up threshold
    input wire logic gnd_loss, // Loss-of-ground detector
    output logic bus_line_drive, // Drive bus_line dominant high
    output logic bus_wake_level, // Use high-voltage wake-up level
    output logic slew_ctrl_en, // Wave shaping on slew_program_pin path
    output logic rx_data_o, // Receive pin output value
    output logic rx_data_oe, // Receive pin pull-down enable
    output logic load_switch_on, // Load resistor switch to ground
    output logic irq, // Interrupt, level, active high
    input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata // Read data, one cycle later
);
    localparam int TCW = $clog2(DOM_TIMEOUT_CYCLES + 1);
    localparam logic [TCW-1:0] TO_LAST = TCW'(DOM_TIMEOUT_CYCLES - 1);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DOM_TIMEOUT_CYCLES < 1)
    begin : g_chk_to
        $error("swcan_ctrl: DOM_TIMEOUT_CYCLES must be at least 1");
    end
    if (RX_FILT_CYCLES < 1)
    begin : g_chk_rx
        $error("swcan_ctrl: RX_FILT_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mode_type mode;
        logic [TCW-1:0] to_cnt;
        logic timed_out;
        logic drive;
        logic wake_lvl;
        logic slew;
        logic rx_oe;
        logic load_sw;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic gnd_loss_prev;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } ctrl_state_type;

    ctrl_state_type st_ff;
    ctrl_state_type nxt_st;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    cond_if tx_c ();
    cond_if m0_c ();
    cond_if m1_c ();
    cond_if norm_c ();
    cond_if wake_c ();
    cond_if gnd_c ();

    assign tx_c.raw = tx_data_n;
    assign m0_c.raw = mode_select0;
    assign m1_c.raw = mode_select1;
    assign norm_c.raw = bus_sense_norm;
    assign wake_c.raw = bus_sense_wake;
    assign gnd_c.raw = gnd_loss;

    // Transmit idles high so a floating pin reads recessive
    cond_filter #(.FILT_LEN(1), .RESET_VAL(1'b1)) u_tx
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(tx_c)
    );

    // Mode selects idle low so a floating pin reads as sleep
    cond_filter #(.FILT_LEN(1), .RESET_VAL(1'b0)) u_m0
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(m0_c)
    );

    cond_filter #(.FILT_LEN(1), .RESET_VAL(1'b0)) u_m1
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(m1_c)
    );

    // Receive paths share one fixed filter length for glitch immunity
    cond_filter #(.FILT_LEN(RX_FILT_CYCLES), .RESET_VAL(1'b0)) u_norm
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(norm_c)
    );

    cond_filter #(.FILT_LEN(RX_FILT_CYCLES), .RESET_VAL(1'b0)) u_wake
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(wake_c)
    );

    cond_filter #(.FILT_LEN(1), .RESET_VAL(1'b0)) u_gnd
    (
        .clk(clk),
        .reset_n(reset_n),
        .port(gnd_c)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Events raised this cycle, one per status bit
    logic [EV_W-1:0] ev;
    logic wr_status;
    logic wr_mask;
    mode_type mode_dec;

    // Mode decode straight from the synced select pins
    always_comb
    begin
        case ({m1_c.clean, m0_c.clean})
            2'b00: mode_dec = mode_sleep;
            2'b01: mode_dec = mode_high_speed;
            2'b10: mode_dec = mode_wake_call;
            2'b11: mode_dec = mode_normal;
            default: mode_dec = mode_sleep;
        endcase
    end

    // STATE and unmapped offsets simply ignore writes
    assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
    assign wr_mask = reg_wr && (reg_addr == OFS_MASK);

    // One pass works out every register's next value
    always_comb
    begin
        nxt_st = st_ff;
        ev = '0;

        // Mode follows the pins only; bus wake-ups never change it
        nxt_st.mode = mode_dec;
        ev[EV_MODE] = (mode_dec != st_ff.mode);

        // Dominant timeout; a high transmit input clears it the same cycle
        // The synchroniser still delays the clear by three clocks
        if (tx_c.clean)
        begin
            nxt_st.to_cnt = '0;
            nxt_st.timed_out = 1'b0;
        end
        else if (!st_ff.timed_out)
        begin
            if (st_ff.to_cnt == TO_LAST)
            begin
                nxt_st.timed_out = 1'b1;
                ev[EV_TIMEOUT] = 1'b1;
            end
            else
            begin
                nxt_st.to_cnt = st_ff.to_cnt + 1'b1;
            end
        end

        // Driver: dominant while transmit is low, unless timed out
        // Sleep keeps the driver off to hold the quiescent current down
        nxt_st.drive = !tx_c.clean && !nxt_st.timed_out
            && (mode_dec != mode_sleep);

        // Level and shaping selection per mode
        case (mode_dec)
            mode_high_speed:
            begin
                nxt_st.wake_lvl = 1'b0;
                nxt_st.slew = 1'b0;
            end
            mode_wake_call:
            begin
                nxt_st.wake_lvl = 1'b1;
                nxt_st.slew = 1'b1;
            end
            mode_normal:
            begin
                nxt_st.wake_lvl = 1'b0;
                nxt_st.slew = 1'b1;
            end
            default:
            begin
                nxt_st.wake_lvl = 1'b0;
                nxt_st.slew = 1'b1;
            end
        endcase

        // Receive path: in sleep only the wake-up comparator counts
        if (mode_dec == mode_sleep)
        begin
            nxt_st.rx_oe = wake_c.clean;
            // A wake level already present on entry to sleep raises no event
            ev[EV_WAKE] = wake_c.clean && !st_ff.rx_oe;
        end
        else
        begin
            nxt_st.rx_oe = norm_c.clean;
        end

        // Loss of ground opens the switch in every mode, sleep included
        nxt_st.load_sw = !gnd_c.clean;
        nxt_st.gnd_loss_prev = gnd_c.clean;
        ev[EV_GND_LOSS] = gnd_c.clean && !st_ff.gnd_loss_prev;

        // Status: write one to clear, a new event in the same cycle wins
        if (wr_status)
        begin
            nxt_st.status = (st_ff.status & ~reg_wdata[EV_W-1:0]) | ev;
        end
        else
        begin
            nxt_st.status = st_ff.status | ev;
        end

        // A mask write replaces every enable at once
        if (wr_mask)
        begin
            nxt_st.mask = reg_wdata[EV_W-1:0];
        end

        // Taken from the next state so irq moves on the same edge as status
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // Read data valid for exactly the cycle after the strobe
        nxt_st.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_STATUS:
                begin
                    nxt_st.rdata[EV_W-1:0] = st_ff.status;
                end
                OFS_MASK:
                begin
                    nxt_st.rdata[EV_W-1:0] = st_ff.mask;
                end
                OFS_STATE:
                begin
                    nxt_st.rdata[ST_MODE_LSB +: 2] = st_ff.mode;
                    nxt_st.rdata[ST_TIMEOUT] = st_ff.timed_out;
                    nxt_st.rdata[ST_DRIVE] = st_ff.drive;
                    nxt_st.rdata[ST_WAKE_LVL] = st_ff.wake_lvl;
                    nxt_st.rdata[ST_SLEW] = st_ff.slew;
                    nxt_st.rdata[ST_LOAD_SW] = st_ff.load_sw;
                    nxt_st.rdata[ST_RX_DOM] = st_ff.rx_oe;
                end
                default:
                begin
                    nxt_st.rdata = '0; // Unmapped reads return zero
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset leaves the bus released and the load switch closed
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_ff.mode <= mode_sleep;
            st_ff.to_cnt <= '0;
            st_ff.timed_out <= 1'b0;
            st_ff.drive <= 1'b0;
            st_ff.wake_lvl <= 1'b0;
            st_ff.slew <= 1'b1;
            st_ff.rx_oe <= 1'b0;
            st_ff.load_sw <= 1'b1;
            st_ff.status <= '0;
            st_ff.mask <= MASK_RESET;
            st_ff.gnd_loss_prev <= 1'b0;
            st_ff.rdata <= '0;
            st_ff.irq <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flops, except rx_data_o, which is tied low
    // ------------------------------------------------------------
    assign bus_line_drive = st_ff.drive;
    assign bus_wake_level = st_ff.wake_lvl;
    assign slew_ctrl_en = st_ff.slew;
    assign rx_data_oe = st_ff.rx_oe;
    // The receive value never changes; only its enable toggles
    assign rx_data_o = 1'b0; // Open drain: only ever pulls low
    assign load_switch_on = st_ff.load_sw;
    assign irq = st_ff.irq;
    assign reg_rdata = st_ff.rdata;
endmodule
`default_nettype wire

// >>> dv/swcan_props_properties.sv
// Purpose: Concurrent checks on the transceiver control ports
// Assumes: One clock, synchronous active-low reset
// Notes: Windows leave room for the input synchronisers and filter
`timescale 1ns/1ps
`default_nettype none
module swcan_props
    import swcan_pkg::*;
#(
    parameter int DOM_TIMEOUT_CYCLES = 24, // Dominant timeout count
    parameter int RX_FILT_CYCLES = 2 // Receive filter length
)
(
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic tx_data_n, // Transmit request
    input wire logic mode_select0, // Mode bit 0
    input wire logic mode_select1, // Mode bit 1
    input wire logic bus_sense_norm, // Normal threshold
    input wire logic bus_sense_wake, // Wake threshold
    input wire logic gnd_loss, // Ground loss
    input wire logic bus_line_drive, // Driver on
    input wire logic bus_wake_level, // Wake level
    input wire logic slew_ctrl_en, // Wave shaping
    input wire logic rx_data_oe, // Receive pulled low
    input wire logic load_switch_on // Load switch
);
    // ----
    // Helpers
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    int low_cnt_ff;
    // Saturating count of sampled transmit-low cycles
    always_ff @(posedge clk)
    begin
        if (!reset_n || tx_data_n)
            low_cnt_ff <= 0;
        else if (low_cnt_ff < 1000)
            low_cnt_ff <= low_cnt_ff + 1;
    end
    // Transmit falls, then stays low in a mode with mode_select1 high
    sequence tx_start_s;
        tx_data_n ##1 (!tx_data_n && mode_select1) [*6];
    endsequence
    sequence wake_start_s;
        tx_data_n ##1 (!tx_data_n && !mode_select0 && mode_select1) [*6];
    endsequence
    // Transmit settled high, then falls
    sequence tx_fall_s;
        tx_data_n [*6] ##1 !tx_data_n;
    endsequence
    // ----
    // Properties
    // ----
    drive_on_a: assert property (tx_start_s |-> bus_line_drive)
        else $error("driver off after transmit low");
    tx_idle_a: assert property (tx_data_n [*6] |-> !bus_line_drive)
        else $error("driver on while transmit high");
    dom_tmo_a: assert property (low_cnt_ff > DOM_TIMEOUT_CYCLES + 6 |-> !bus_line_drive)
        else $error("driver on past the timeout");
    wake_lvl_a: assert property (wake_start_s |-> bus_wake_level)
        else $error("wake level missing in wake-up call mode");
    norm_lvl_a: assert property (mode_select0 [*6] |-> !bus_wake_level)
        else $error("wake level in a normal-level mode");
    hs_slew_a: assert property ((mode_select0 && !mode_select1) [*6] |-> !slew_ctrl_en)
        else $error("shaping on in high-speed mode");
    shape_on_a: assert property ((!mode_select0 || mode_select1) [*6] |-> slew_ctrl_en)
        else $error("shaping off outside high-speed mode");
    rx_dom_a: assert property (((mode_select0 || mode_select1) && bus_sense_norm) [*8]
        |-> rx_data_oe)
        else $error("receive not low on dominant bus");
    rx_rec_a: assert property (((mode_select0 || mode_select1) && !bus_sense_norm) [*8]
        |-> !rx_data_oe)
        else $error("receive low on recessive bus");
    rx_sleep_a: assert property ((!mode_select0 && !mode_select1 && !bus_sense_wake) [*8]
        |-> !rx_data_oe)
        else $error("normal-level traffic seen in sleep");
    gnd_open_a: assert property (gnd_loss [*8] |-> !load_switch_on)
        else $error("load switch closed on ground loss");
    // Two sync stages mean the driver cannot answer a fall within three clocks
    sync_lag_a: assert property (tx_fall_s |-> (!bus_line_drive) [*3])
        else $error("driver answered transmit before synchronising");
endmodule
bind swcan_ctrl swcan_props #(
    .DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES),
    .RX_FILT_CYCLES(RX_FILT_CYCLES)
) props_u (.clk, .reset_n, .tx_data_n, .mode_select0, .mode_select1, .bus_sense_norm,
    .bus_sense_wake, .gnd_loss, .bus_line_drive, .bus_wake_level, .slew_ctrl_en,
    .rx_data_oe, .load_switch_on);
`default_nettype wire

// >>> dv/swcan_bus_model.sv
// Purpose: Behavioural single-wire bus with other nodes on it
// Assumes: Bus rests recessive low through the load resistors
// Notes: Comparators answer at once; the design's filter adds delay
`timescale 1ns/1ps
`default_nettype none
module swcan_bus_model
(
    input wire logic bus_line_drive, // Our driver on
    input wire logic bus_wake_level, // Our driver at wake level
    input wire logic node_dom, // Other node, normal level
    input wire logic node_wake, // Other node, wake level
    output logic bus_sense_norm, // Above normal threshold
    output logic bus_sense_wake // Above wake threshold
);
    // Any driver lifts the wire; released, it falls low
    assign bus_sense_norm = bus_line_drive | node_dom | node_wake;
    // Only wake-level drive crosses the higher threshold
    assign bus_sense_wake = (bus_line_drive & bus_wake_level) | node_wake;
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the transceiver control logic
// Assumes: Short timeout and filter parameters for simulation
// Notes: Read results are queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import swcan_pkg::*;
;
    localparam int TMO = 24;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tx_data_n = 1'b1;
    logic mode_select0 = 1'b0;
    logic mode_select1 = 1'b0;
    logic gnd_loss = 1'b0;
    logic node_dom = 1'b0;
    logic node_wake = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic bus_sense_norm, bus_sense_wake, bus_line_drive, bus_wake_level;
    logic slew_ctrl_en, rx_data_o, rx_data_oe, load_switch_on, irq;
    logic rd_q = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] care_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    always #2 clk = ~clk;
    swcan_ctrl #(.DOM_TIMEOUT_CYCLES(TMO), .RX_FILT_CYCLES(2)) dut_u (.clk(clk),
        .reset_n(reset_n), .tx_data_n(tx_data_n), .mode_select0(mode_select0),
        .mode_select1(mode_select1), .bus_sense_norm(bus_sense_norm),
        .bus_sense_wake(bus_sense_wake), .gnd_loss(gnd_loss),
        .bus_line_drive(bus_line_drive), .bus_wake_level(bus_wake_level),
        .slew_ctrl_en(slew_ctrl_en), .rx_data_o(rx_data_o), .rx_data_oe(rx_data_oe),
        .load_switch_on(load_switch_on), .irq(irq), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    swcan_bus_model bus_u (.bus_line_drive(bus_line_drive), .bus_wake_level(bus_wake_level),
        .node_dom(node_dom), .node_wake(node_wake), .bus_sense_norm(bus_sense_norm),
        .bus_sense_wake(bus_sense_wake));
    // ----
    // Tasks
    // ----
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Step past the edge so design updates have landed
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmpb(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cmpw(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] c);
        check_count++;
        if ((reg_rdata & c) !== (e & c))
        begin
            n_mismatch++;
            $display("[ERR] reg_rdata expected %h seen %h", e, reg_rdata);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Note the expected word and care mask, then strobe one cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] c);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        care_q.push_back(c);
        @(posedge clk);
        reg_rd <= 1'b0;
        w(2);
    endtask
    task automatic setm(input logic [1:0] m);
        @(posedge clk);
        mode_select0 <= m[0];
        mode_select1 <= m[1];
        w(12);
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_q)
            cmpw(exp_q.pop_front(), care_q.pop_front());
        rd_q <= reg_rd;
    end
    // Hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        conclude();
    end
    // ----
    // Scenarios
    // ----
    initial
    begin
        void'($urandom(78758));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        w(4);
        cmpb("slew_ctrl_en", 1'b1, slew_ctrl_en);
        cmpb("load_switch_on", 1'b1, load_switch_on);
        cmpb("irq", 1'b0, irq);
        cmpb("rx_data_o", 1'b0, rx_data_o);
        rd(OFS_MASK, 32'h0, '1);
        wr(OFS_STATE, '1);
        rd(OFS_STATE, 32'h60, '1);
        rd(4'hC, 32'h0, '1);
        for (int m = 0; m < 4; m++)
        begin
            setm(m[1:0]);
            rd(OFS_STATE, {24'h0, 2'b01, m != 1, 3'h0, m[1:0]}, 32'hFFFF_FF6F);
        end
        rd(OFS_STATUS, 32'h8, '1);
        wr(OFS_STATUS, 32'hF);
        rd(OFS_STATUS, 32'h0, '1);
        @(posedge clk) tx_data_n <= 1'b0;
        w(14);
        cmpb("bus_line_drive", 1'b1, bus_line_drive);
        cmpb("bus_wake_level", 1'b0, bus_wake_level);
        cmpb("rx_data_oe", 1'b1, rx_data_oe);
        @(posedge clk) tx_data_n <= 1'b1;
        setm(2'h2);
        @(posedge clk) tx_data_n <= 1'b0;
        w(10);
        cmpb("bus_wake_level", 1'b1, bus_wake_level);
        @(posedge clk) tx_data_n <= 1'b1;
        // Stuck dominant request, then release and retry
        setm(2'h3);
        wr(OFS_MASK, 32'h2);
        @(posedge clk) tx_data_n <= 1'b0;
        w(TMO);
        cmpb("bus_line_drive", 1'b1, bus_line_drive);
        w(10);
        cmpb("bus_line_drive", 1'b0, bus_line_drive);
        cmpb("irq", 1'b1, irq);
        rd(OFS_STATE, 32'h4, 32'hC);
        @(posedge clk) tx_data_n <= 1'b1;
        w(5);
        rd(OFS_STATE, 32'h0, 32'h4);
        @(posedge clk) tx_data_n <= 1'b0;
        w(10);
        cmpb("bus_line_drive", 1'b1, bus_line_drive);
        @(posedge clk) tx_data_n <= 1'b1;
        wr(OFS_STATUS, 32'hF);
        w(2);
        cmpb("irq", 1'b0, irq);
        // Sleep: normal traffic hidden, wake traffic passed
        setm(2'h0);
        @(posedge clk) node_dom <= 1'b1;
        w(12);
        cmpb("rx_data_oe", 1'b0, rx_data_oe);
        @(posedge clk) node_wake <= 1'b1;
        w(12);
        cmpb("rx_data_oe", 1'b1, rx_data_oe);
        @(posedge clk) node_wake <= 1'b0;
        w(12);
        rd(OFS_STATE, 32'h0, 32'h3);
        rd(OFS_STATUS, 32'h1, 32'h1);
        @(posedge clk) node_dom <= 1'b0;
        wr(OFS_STATUS, 32'hF);
        wr(OFS_MASK, 32'h4);
        @(posedge clk) gnd_loss <= 1'b1;
        w(10);
        cmpb("load_switch_on", 1'b0, load_switch_on);
        cmpb("irq", 1'b1, irq);
        wr(OFS_MASK, 32'h0);
        w(2);
        cmpb("irq", 1'b0, irq);
        wr(OFS_MASK, 32'h4);
        wr(OFS_STATUS, 32'h4);
        w(2);
        cmpb("irq", 1'b0, irq);
        @(posedge clk) gnd_loss <= 1'b0;
        w(10);
        cmpb("load_switch_on", 1'b1, load_switch_on);
        // Random traffic in normal mode, judged by the checker
        setm(2'h3);
        repeat (24)
        begin
            @(posedge clk) tx_data_n <= 1'($urandom % 2);
            node_dom <= 1'($urandom % 2);
            w(8);
        end
        @(posedge clk) tx_data_n <= 1'b1;
        w(4);
        conclude();
    end
endmodule
`default_nettype wire
